// >>> rtl/tdseq_pkg.sv
// tdseq_pkg: constants, register map and types of the transfer delay sequencer
//
// How it works
// - stop at centre off for the dwell
// - dwell applies toward both sources
// - dwell is 0 s or 5 s, reset 0 s
// - auto return runs confirm timer, watching both
// - normal lost during confirm cancels return
// - source two lost, normal good: return now
// - confirm timer 0..60 minutes, nine steps
// - generator mode waits start delay, default 3 s
// - start delay needs external power or module
// - start delay 0..60 seconds, nine steps
// - load shed asserted after shed delay
// - cool-down after normal closes, then stop
// - restart in generator mode runs cool-down too
// - cool-down only after start delay or confirm
// - return to normal only in auto return
package tdseq_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_HZ       = 250_000_000; // pclk rate in hz
  localparam int          TICK_S       = 1;           // tick period in seconds
  localparam int          SEC_CYCLES   = CLK_HZ * TICK_S;
  localparam logic [11:0] DWELL_LONG_S = 12'h005;     // long centre-off dwell
  localparam logic [11:0] DWELL_NONE_S = 12'h000;     // no centre-off dwell
  localparam logic [11:0] MIN_TO_S     = 12'h03c;     // seconds per minute

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFF     = 8'h00;       // control bits
  localparam logic [7:0]  CFG_OFF      = 8'h04;       // delay settings
  localparam logic [7:0]  STAT_OFF     = 8'h08;       // read-only status
  localparam int          CTRL_AUTO    = 0;           // auto return enable
  localparam int          CTRL_UG      = 1;           // utility-generator mode
  localparam int          CTRL_GMOD    = 2;           // start module selected
  localparam int          CTRL_DWELL   = 3;           // 1 = 5 s dwell
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  localparam int          RET_LSB      = 0;           // confirm step index
  localparam int          GST_LSB      = 4;           // start delay index
  localparam int          SHED_LSB     = 8;           // shed delay seconds
  localparam int          COOL_LSB     = 16;          // cool delay seconds
  localparam logic [3:0]  RET_IDX_RST  = 4'h1;        // 1 minute
  localparam logic [3:0]  GST_IDX_RST  = 4'h3;        // 3 seconds
  localparam logic [7:0]  SHED_RST     = 8'h00;       // 0 seconds
  localparam logic [7:0]  COOL_RST     = 8'h3c;       // 60 seconds

  // ---------------------------------------------------------------
  // timer slots
  // ---------------------------------------------------------------
  localparam int N_TMR     = 6;
  localparam int TMR_DWELL = 0;
  localparam int TMR_RET   = 1;
  localparam int TMR_GST   = 2;
  localparam int TMR_SHED  = 3;
  localparam int TMR_COOL  = 4;
  localparam int TMR_CONF  = 5;

  // one-hot sequencer states
  typedef enum logic [5:0] {
    ST_NORM = 6'h01, // load on normal
    ST_WAIT = 6'h02, // normal lost, waiting for source two
    ST_OFFA = 6'h04, // centre off toward source two
    ST_ALT  = 6'h08, // load on source two
    ST_RET  = 6'h10, // return confirmation running
    ST_OFFN = 6'h20  // centre off toward normal
  } tdseq_state_t;

  // nine-step table, scaled to seconds when minutes is set
  function automatic logic [11:0] tdseq_delay_s(input logic [3:0] idx,
                                                input logic       minutes);
    logic [11:0] step;
    step = 12'h03c;
    unique case (idx)
      4'h0:    step = 12'h000;
      4'h1:    step = 12'h001;
      4'h2:    step = 12'h002;
      4'h3:    step = 12'h003;
      4'h4:    step = 12'h005;
      4'h5:    step = 12'h00a;
      4'h6:    step = 12'h014;
      4'h7:    step = 12'h01e;
      default: step = 12'h03c;
    endcase
    return minutes ? 12'(step * MIN_TO_S) : step;
  endfunction : tdseq_delay_s

endpackage : tdseq_pkg

// >>> rtl/tdseq_tick.sv
// tdseq_tick: one-cycle pulse once per second of pclk
`timescale 1ns/1ns
module tdseq_tick
  import tdseq_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES // cycles between ticks
)(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [27:0] cnt;  // cycles since last tick
    logic        tick; // registered pulse
  } tdseq_tick_t;

  tdseq_tick_t s_reg;
  tdseq_tick_t s_next;

  // free-running divider
  always_comb
  begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt >= 28'(SEC_CYC - 1))
    begin
      s_next.cnt  = 28'h0000000;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.cnt = s_reg.cnt + 28'h0000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign tick = s_reg.tick;

  tick_single_a: assert property (@(posedge pclk) disable iff (!presetn)
    (SEC_CYC > 1 && tick) |=> !tick)
    else $error("tick lasted more than one cycle");

endmodule : tdseq_tick

// >>> rtl/tdseq_timer.sv
// tdseq_timer: seconds delay timer that restarts on each fresh run
`timescale 1ns/1ns
module tdseq_timer
  import tdseq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic [11:0] limit,
  output logic             done
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        run_q; // run seen last cycle
    logic [11:0] cnt;   // ticks counted
    logic        done;  // delay expired
  } tdseq_tmr_t;

  tdseq_tmr_t s_reg;
  tdseq_tmr_t s_next;

  // a dropped run clears everything, so a new run starts from zero
  always_comb
  begin
    s_next       = s_reg;
    s_next.run_q = run;
    if (!run || !s_reg.run_q)
    begin
      s_next.cnt  = 12'h000;
      s_next.done = 1'b0;
    end
    else if (tick && !s_reg.done)
    begin
      if (s_reg.cnt == limit)
        s_next.done = 1'b1;
      else
        s_next.cnt = s_reg.cnt + 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign done = s_reg.done;

  restart_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && !s_reg.run_q) |=> (s_reg.cnt == 12'h000 && !done))
    else $error("timer did not restart from zero");

  zero_next_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && s_reg.run_q && tick && !done && s_reg.cnt == limit) |=> done)
    else $error("timer missed its expiry tick");

endmodule : tdseq_timer

// >>> rtl/tdseq_top.sv
// tdseq_top: apb registers and the transfer, generator and shed sequencer
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ns
module tdseq_top
  import tdseq_pkg::*;
#(
  parameter int SEC_CYCLES_P = SEC_CYCLES // shorten for simulation
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        normal_ok,
  input  wire logic        source_two_ok,
  input  wire logic        ext_power,
  output logic             pos_normal,
  output logic             pos_off,
  output logic             pos_alt,
  output logic             gen_start,
  output logic             gen_stop,
  output logic             load_shed
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    tdseq_state_t st;        // switch sequence
    logic [3:0]   ctrl;      // control register
    logic [3:0]   ret_idx;   // confirm step
    logic [3:0]   gst_idx;   // start delay step
    logic [7:0]   shed_s;    // shed delay
    logic [7:0]   cool_s;    // cool delay
    logic         gen_run;   // start command held
    logic         gen_stop;  // stop command held
    logic         cool_ok;   // generator may be cooled
    logic         cool_pend; // cool-down still owed
    logic [31:0]  rdata;     // read data for access phase
    logic         slverr;    // error for access phase
  } tdseq_main_t;

  tdseq_main_t s_reg;
  tdseq_main_t s_next;

  // ---------------------------------------------------------------
  // derived controls
  // ---------------------------------------------------------------
  logic              tick;       // one pulse a second
  logic [N_TMR-1:0]  t_run;      // timer run levels
  logic [N_TMR-1:0]  t_done;     // timer expiries
  logic [11:0]       t_lim [N_TMR]; // timer limits in seconds
  logic              auto_ret;   // auto return mode
  logic              ug;         // utility-generator mode
  logic              gen_avail;  // start delay function usable
  logic              wr_en;      // apb write in access phase
  logic              setup;      // apb setup phase
  logic              hit;        // mapped address

  // mode bits from control, apb phase decodes from the bus
  assign auto_ret  = s_reg.ctrl[CTRL_AUTO];
  assign ug        = s_reg.ctrl[CTRL_UG];
  assign gen_avail = ext_power | s_reg.ctrl[CTRL_GMOD];
  assign wr_en     = psel & penable & pwrite;
  assign setup     = psel & ~penable;
  assign hit       = (paddr == CTRL_OFF) | (paddr == CFG_OFF) | (paddr == STAT_OFF);

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  // one shared second tick keeps every delay on the same grid
  // cost of sharing: each delay ends up to one tick period late
  tdseq_tick #(
    .SEC_CYC (SEC_CYCLES_P)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // what starts and stops each delay
  always_comb
  begin
    t_run[TMR_DWELL] = (s_reg.st == ST_OFFA) | (s_reg.st == ST_OFFN);
    t_lim[TMR_DWELL] = s_reg.ctrl[CTRL_DWELL] ? DWELL_LONG_S : DWELL_NONE_S;
    t_run[TMR_RET]   = (s_reg.st == ST_RET);
    t_lim[TMR_RET]   = tdseq_delay_s(s_reg.ret_idx, 1'b1);
    // only asked for while normal is down and no start is held yet
    t_run[TMR_GST]   = ug & gen_avail & ~normal_ok & ~s_reg.gen_run;
    t_lim[TMR_GST]   = tdseq_delay_s(s_reg.gst_idx, 1'b0);
    t_run[TMR_SHED]  = (s_reg.st == ST_ALT) | (s_reg.st == ST_RET);
    t_lim[TMR_SHED]  = {4'h0, s_reg.shed_s};
    // cool-down waits for normal closed and a proven generator
    t_run[TMR_COOL]  = ug & s_reg.cool_pend & s_reg.cool_ok
                       & (s_reg.st == ST_NORM) & normal_ok;
    t_lim[TMR_COOL]  = {4'h0, s_reg.cool_s};
    // source two held healthy for a whole confirm period
    t_run[TMR_CONF]  = source_two_ok;
    t_lim[TMR_CONF]  = tdseq_delay_s(s_reg.ret_idx, 1'b1);
  end

  // one instance per delay, all on the shared tick
  generate
    for (genvar g = 0; g < N_TMR; g++)
    begin : g_tmr
      tdseq_timer u_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick),
        .run     (t_run[g]),
        .limit   (t_lim[g]),
        .done    (t_done[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;

    // apb read data and error are captured in setup, shown in access
    if (setup)
    begin
      s_next.slverr = ~hit;
      s_next.rdata  = 32'h00000000;
      if (paddr == CTRL_OFF)
        s_next.rdata = {28'h0000000, s_reg.ctrl};
      else if (paddr == CFG_OFF)
        s_next.rdata = {8'h00, s_reg.cool_s, s_reg.shed_s,
                        s_reg.gst_idx, s_reg.ret_idx};
      else if (paddr == STAT_OFF)
        s_next.rdata = {16'h0000, s_reg.cool_pend, s_reg.cool_ok,
                        s_reg.gen_stop, s_reg.gen_run, t_done, s_reg.st};
    end

    // no write strobes: a write always replaces the whole register
    // writes land in the access phase; status ignores writes
    if (wr_en && paddr == CTRL_OFF)
      s_next.ctrl = pwdata[3:0];
    if (wr_en && paddr == CFG_OFF)
    begin
      s_next.ret_idx = pwdata[RET_LSB +: 4];
      s_next.gst_idx = pwdata[GST_LSB +: 4];
      s_next.shed_s  = pwdata[SHED_LSB +: 8];
      s_next.cool_s  = pwdata[COOL_LSB +: 8];
    end

    // switch sequence
    unique case (s_reg.st)
      ST_NORM:
      begin
        // normal lost: wait for source two before moving
        if (!normal_ok)
          s_next.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        // normal back before source two: stay put
        if (normal_ok)
          s_next.st = ST_NORM;
        else if (source_two_ok)
          s_next.st = ST_OFFA;
      end
      ST_OFFA:
      begin
        // mechanism held at centre off until the dwell expires
        if (t_done[TMR_DWELL])
          s_next.st = ST_ALT;
      end
      ST_ALT:
      begin
        // without auto return the load never comes back by itself
        if (normal_ok && auto_ret)
          s_next.st = ST_RET;
      end
      ST_RET:
      begin
        // normal loss wins over source two loss: never move to a dead side
        if (!normal_ok)
          s_next.st = ST_ALT;
        else if (!source_two_ok)
          s_next.st = ST_OFFN;
        else if (t_done[TMR_RET])
          s_next.st = ST_OFFN;
      end
      ST_OFFN:
      begin
        // same dwell timer as the outgoing move, restarted on entry
        if (t_done[TMR_DWELL])
          s_next.st = ST_NORM;
      end
      default:
      begin
        // illegal code: fall back to the normal side
        s_next.st = ST_NORM;
      end
    endcase

    // generator start, proof and cool-down
    // a start expiry also owes a cool-down and proves the set
    if (t_done[TMR_GST])
    begin
      s_next.gen_run   = 1'b1;
      s_next.gen_stop  = 1'b0;
      s_next.cool_pend = 1'b1;
    end
    // stop ends the run and spends the proof
    if (t_done[TMR_COOL])
    begin
      s_next.gen_run   = 1'b0;
      s_next.gen_stop  = 1'b1;
      s_next.cool_pend = 1'b0;
      s_next.cool_ok   = 1'b0;
    end
    // set wins over the clear above
    if (t_done[TMR_CONF] || t_done[TMR_GST])
      s_next.cool_ok = 1'b1;
    // commands only exist in generator mode
    if (!ug)
    begin
      s_next.gen_run  = 1'b0;
      s_next.gen_stop = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // cool_pend comes out of reset set, so a restart owes a cool-down
  // only constants here; the reset branch must not read other state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg           <= '0;
      s_reg.st        <= ST_NORM;
      s_reg.ctrl      <= CTRL_RST;
      s_reg.ret_idx   <= RET_IDX_RST;
      s_reg.gst_idx   <= GST_IDX_RST;
      s_reg.shed_s    <= SHED_RST;
      s_reg.cool_s    <= COOL_RST;
      s_reg.cool_pend <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // zero-wait slave: every access completes in its first access cycle
  assign pready     = 1'b1;
  assign prdata     = s_reg.rdata;
  assign pslverr    = s_reg.slverr;
  // switch drive decodes the one-hot state flops, so exactly one is high
  assign pos_normal = (s_reg.st == ST_NORM) | (s_reg.st == ST_WAIT);
  assign pos_off    = (s_reg.st == ST_OFFA) | (s_reg.st == ST_OFFN);
  assign pos_alt    = (s_reg.st == ST_ALT) | (s_reg.st == ST_RET);
  assign gen_start  = s_reg.gen_run;
  assign gen_stop   = s_reg.gen_stop;
  // shed is the timer flop itself; it lags the switch by one cycle on exit
  assign load_shed  = t_done[TMR_SHED];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // every check runs on pclk and rests while reset is held

  alt_via_off_a: assert property ($rose(pos_alt) |-> $past(pos_off))
    else $error("load reached source two without centre off");

  normal_via_off_a: assert property (
    $rose(pos_normal) |-> ($past(pos_off) && $past(s_reg.st) == ST_OFFN))
    else $error("load returned to normal without centre off");

  dwell_values_a: assert property (
    t_lim[TMR_DWELL] == (s_reg.ctrl[CTRL_DWELL] ? 12'h005 : 12'h000))
    else $error("centre-off dwell not 0 s or 5 s");

  return_cancel_a: assert property (
    (s_reg.st == ST_RET && !normal_ok) |=> s_reg.st == ST_ALT)
    else $error("return not cancelled on normal loss");

  return_now_a: assert property (
    (s_reg.st == ST_RET && normal_ok && !source_two_ok) |=> s_reg.st == ST_OFFN)
    else $error("return not immediate on source two loss");

  no_auto_stay_a: assert property (
    (s_reg.st == ST_ALT && !auto_ret) |=> s_reg.st != ST_RET)
    else $error("return started without auto return");

  start_gated_a: assert property (
    $rose(gen_start) |-> ($past(ug) && $past(gen_avail) && $past(t_done[TMR_GST])))
    else $error("generator start without delay or availability");

  stop_after_cool_a: assert property (
    $rose(gen_stop) |-> ($past(t_done[TMR_COOL]) && pos_normal))
    else $error("generator stop without cool-down on normal");

  cool_guard_a: assert property (
    $rose(s_reg.cool_ok) |-> ($past(t_done[TMR_GST]) || $past(t_done[TMR_CONF])))
    else $error("cool-down started before generator proven");

  shed_on_alt_a: assert property (load_shed |-> $past(pos_alt))
    else $error("load shed while not on source two");

  pos_onehot_a: assert property ($onehot({pos_normal, pos_off, pos_alt}))
    else $error("switch drive not exactly one position");

  stop_drops_start_a: assert property (gen_stop |-> !gen_start)
    else $error("generator start and stop both driven");

  shed_drops_a: assert property ((load_shed && !pos_alt) |=> !load_shed)
    else $error("load shed held after leaving source two");

  start_needs_ug_a: assert property (!ug |=> !gen_start)
    else $error("generator start outside generator mode");

  ret_limit_a: assert property (t_lim[TMR_RET] <= 12'he10)
    else $error("confirm delay beyond sixty minutes");

  gst_limit_a: assert property (t_lim[TMR_GST] <= 12'h03c)
    else $error("start delay beyond sixty seconds");

endmodule : tdseq_top

// >>> testbench/tb_top.sv
// tb_top: self-checking bench for the transfer delay sequencer
`timescale 1ns/1ns
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) \
    begin \
      n_fail++; \
      $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_top
  import tdseq_pkg::*;
;
  localparam int SEC = 8; // short tick keeps the run small
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, normal_ok, source_two_ok, ext_power;
  logic        pos_normal, pos_off, pos_alt, gen_start, gen_stop, load_shed;
  logic        n_cmd = 1'b1;   // normal supply commanded healthy
  logic        a_cmd = 1'b1;   // alternate supply commanded healthy
  logic        gen_src = 1'b0; // source two is a generator
  logic        ext_cmd = 1'b0; // external power commanded
  logic [5:0]  obs;            // outputs indexed for waiting
  int          n_fail = 0;
  int          cmp_count = 0;
  int          gs[9] = '{0, 1, 2, 3, 5, 10, 20, 30, 60}; // start delay steps
  assign obs = {load_shed, gen_stop, gen_start, pos_alt, pos_off, pos_normal};

  always #2 pclk = ~pclk;

  tdseq_top #(.SEC_CYCLES_P(SEC)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .normal_ok(normal_ok),
    .source_two_ok(source_two_ok), .ext_power(ext_power), .pos_normal(pos_normal),
    .pos_off(pos_off), .pos_alt(pos_alt), .gen_start(gen_start), .gen_stop(gen_stop),
    .load_shed(load_shed));

  tdseq_partner part (.pclk(pclk), .n_cmd(n_cmd), .a_cmd(a_cmd), .gen_src(gen_src),
    .ext_cmd(ext_cmd), .gen_start(gen_start), .gen_stop(gen_stop),
    .normal_ok(normal_ok), .source_two_ok(source_two_ok), .ext_power(ext_power));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // reset for eight cycles, supplies healthy, generator off
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    n_cmd   <= 1'b1;
    a_cmd   <= 1'b1;
    gen_src <= 1'b0;
    ext_cmd <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      `CHK("pready", 1'b1, pready)
      end_of_test();
    end
  endtask : apb

  // count settled cycles until an output reaches a level, bounded
  task automatic wait_bit(input int b, input int lim, output int n);
    n = 0;
    while (obs[b] !== 1'b1 && n < lim)
    begin
      @(negedge pclk);
      n++;
    end
    if (obs[b] !== 1'b1)
    begin
      `CHK("output wait", 1'b1, obs[b])
      end_of_test();
    end
  endtask : wait_bit

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] rd;
    logic        er;
    do_reset();
    apb(1'b0, CTRL_OFF, 32'h0, rd, er);
    `CHK("ctrl reset", 32'h0000_0000, rd)
    apb(1'b0, CFG_OFF, 32'h0, rd, er);
    `CHK("cfg reset", 32'h003c_0031, rd)
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    `CHK("unmapped err", 1'b1, er)
    apb(1'b0, STAT_OFF, 32'h0, rd, er);
    `CHK("stat reset", 32'h0000_8001, rd)
    apb(1'b1, CTRL_OFF, 32'hffff_ffff, rd, er);
    apb(1'b0, CTRL_OFF, 32'h0, rd, er);
    `CHK("ctrl bits", 32'h0000_000f, rd)
  endtask : t_regs

  // transfer out and back, centre-off time measured both ways
  task automatic t_dwell(input logic lng);
    logic [31:0] rd;
    logic        er;
    int          n;
    int          hi;
    hi = (lng ? 6 : 1) * SEC + 2;
    do_reset();
    apb(1'b1, CFG_OFF, 32'h003c_0030, rd, er);
    apb(1'b1, CTRL_OFF, {28'h0, lng, 3'b001}, rd, er);
    @(posedge pclk);
    n_cmd <= 1'b0;
    wait_bit(1, 8, n);
    wait_bit(2, hi + 2, n);
    `CHK("dwell to alt", 1'b1, n >= (lng ? 5 * SEC : 0) && n <= hi)
    wait_bit(5, SEC + 3, n);
    `CHK("shed zero", 1'b1, n <= SEC + 2)
    @(posedge pclk);
    n_cmd <= 1'b1;
    wait_bit(1, 2 * SEC + 4, n);
    `CHK("confirm zero", 1'b1, n <= 2 * SEC + 3)
    wait_bit(0, hi + 2, n);
    `CHK("dwell to normal", 1'b1, n >= (lng ? 5 * SEC : 0) && n <= hi)
  endtask : t_dwell

  // one minute confirm: held, abandoned, restarted, cut short
  task automatic t_confirm;
    logic [31:0] rd;
    logic        er;
    int          n;
    do_reset();
    @(posedge pclk);
    n_cmd <= 1'b0;
    wait_bit(2, 3 * SEC, n);
    @(posedge pclk);
    n_cmd <= 1'b1;
    repeat (4 * SEC) @(negedge pclk);
    `CHK("no auto return", 1'b1, pos_alt)
    apb(1'b1, CTRL_OFF, 32'h0000_0001, rd, er);
    repeat (50 * SEC) @(negedge pclk);
    apb(1'b0, STAT_OFF, 32'h0, rd, er);
    `CHK("confirm running", 6'h10, rd[5:0])
    @(posedge pclk);
    n_cmd <= 1'b0;
    repeat (3) @(negedge pclk);
    apb(1'b0, STAT_OFF, 32'h0, rd, er);
    `CHK("return abandoned", 6'h08, rd[5:0])
    @(posedge pclk);
    n_cmd <= 1'b1;
    repeat (20 * SEC) @(negedge pclk);
    `CHK("timer restarted", 1'b1, pos_alt)
    @(posedge pclk);
    a_cmd <= 1'b0;
    wait_bit(1, 4, n);
    `CHK("return at once", 1'b1, n <= 3)
  endtask : t_confirm

  // generator start, transfer, return and cool-down stop
  task automatic t_gen(input logic [1:0] en, input int idx);
    logic [31:0] rd;
    logic        er;
    int          n;
    do_reset();
    gen_src <= 1'b1;
    ext_cmd <= en[0];
    apb(1'b1, CFG_OFF, {16'h0002, 8'h00, 4'(idx), 4'h0}, rd, er);
    apb(1'b1, CTRL_OFF, {29'h0, en[1], 2'b11}, rd, er);
    @(posedge pclk);
    n_cmd <= 1'b0;
    if (en == 2'b00)
    begin
      repeat (10 * SEC) @(negedge pclk);
      `CHK("start blocked", 1'b0, gen_start)
      return;
    end
    wait_bit(3, (gs[idx] + 1) * SEC + 6, n);
    `CHK("start delay", 1'b1, n >= gs[idx] * SEC && n <= (gs[idx] + 1) * SEC + 4)
    wait_bit(2, 3 * SEC, n);
    @(posedge pclk);
    n_cmd <= 1'b1;
    wait_bit(0, 5 * SEC, n);
    wait_bit(4, 4 * SEC, n);
    `CHK("cool delay", 1'b1, n >= 2 * SEC && n <= 3 * SEC + 3)
    `CHK("stop drops start", 1'b0, gen_start)
  endtask : t_gen

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    t_regs();
    t_dwell(1'b0);
    t_dwell(1'b1);
    t_confirm();
    for (int i = 0; i < 9; i++)
      t_gen(2'b01, i);
    t_gen(2'b10, 3);
    t_gen(2'b00, 3);
    end_of_test();
  end
endmodule : tb_top

// >>> testbench/tdseq_partner.sv
// tdseq_partner: source sensors and generator set seen by the sequencer
`timescale 1ns/1ns
module tdseq_partner #(
  parameter int GEN_READY = 6 // run-up cycles before the set is healthy
)(
  input  wire logic pclk,
  input  wire logic n_cmd,
  input  wire logic a_cmd,
  input  wire logic gen_src,
  input  wire logic ext_cmd,
  input  wire logic gen_start,
  input  wire logic gen_stop,
  output logic      normal_ok = 1'b1,
  output logic      source_two_ok = 1'b1,
  output logic      ext_power = 1'b0
);
  int run_cnt = 0; // generator run-up progress

  // ---------------------------------------------------------------
  // sensors follow the bench commands one cycle late
  // ---------------------------------------------------------------
  // a generator only reads healthy after its run-up, never at once
  always @(posedge pclk)
  begin
    if (!gen_start || gen_stop)
      run_cnt <= 0;
    else if (run_cnt < GEN_READY)
      run_cnt <= run_cnt + 1;
    normal_ok     <= n_cmd;
    ext_power     <= ext_cmd;
    source_two_ok <= a_cmd && (!gen_src || run_cnt >= GEN_READY);
  end
endmodule : tdseq_partner
